/* File: hw/spi_safety_cfg.svh */
// constants for the processor-communication safety block
`ifndef SPI_SAFETY_CFG_SVH
`define SPI_SAFETY_CFG_SVH
// register addresses (7-bit address field of the command byte)
`define ADDR_CRC_EN 7'h0A
`define ADDR_CRC_SEL 7'h0B
`define ADDR_SCRATCH 7'h0F
`define ADDR_MODE 7'h10
`define ADDR_WD_ONE 7'h13
`define ADDR_WD_TWO 7'h14
`define ADDR_WD_KICK 7'h15
`define ADDR_SWE 7'h1C
`define ADDR_FLAG_TOP 7'h50
`define ADDR_FLAG_WD 7'h51
`define ADDR_FLAG_COMM 7'h53
// field positions
`define BIT_ENABLE 0
`define BIT_WRITE 0
`define BIT_FLAG_ANY 7
`define BIT_FLAG_COMM 4
`define BIT_WD_ERR 7
`define BIT_CRC_ERR 4
`define BIT_LEN_ERR 7
`define BIT_WD_TYPE 7
`define BIT_WD_STBY 6
`define BIT_SWE_DIS 7
`define WD_PRE_HI 5
`define WD_PRE_LO 4
`define WD_TIMER_HI 7
`define WD_TIMER_LO 5
`define SWE_SEL_HI 6
`define SWE_SEL_LO 3
// reset values
`define WD_ONE_RESET 8'h40
`define WD_TWO_RESET 8'h20
`define SWE_RESET 8'h48
// crc settings
`define CRC_POLY_DEFAULT 8'h2F
`define CRC_POLY_ALT 8'h1D
`define CRC_INIT 8'hFF
`define CRC_XOR 8'hFF
`define FILLER_BYTE 8'h00
// frame lengths in serial clocks
`define FRAME_SHORT 5'h10
`define FRAME_LONG 5'h18
`define CMD_BITS 5'h08
// timing
`define MS_TIME_NS 32'h000F_4240
`define SYS_PERIOD_NS 32'h0000_0064
`define MS_PER_SEC 10'h3E8
`define INIT_WIN_MS 16'h0096
`define RESTART_MS_DEFAULT 16'h000A
`define SWE_BASE_SEC 10'h01E
`define SWE_KNEE 4'h9
`define SWE_HI_STEP 10'h03C
`define SWE_MAX_SEC 10'h258
`endif

/* File: hw/spi_safety_pkg.sv */
// types shared by the processor-communication safety block
package spi_safety_pkg;
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'b000,
    MODE_RESTART = 3'b001,
    MODE_STANDBY = 3'b010,
    MODE_NORMAL = 3'b011,
    MODE_FAIL_SAFE = 3'b100
  } dev_mode_t;
  typedef enum logic [2:0] {
    WD_IDLE = 3'b000,
    WD_LONG = 3'b001,
    WD_CLOSED = 3'b010,
    WD_OPEN = 3'b011,
    WD_TIMEOUT = 3'b100
  } wd_state_t;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
    logic [7:0] crc;
    logic [4:0] clocks;
    logic empty;
  } frame_t;
  typedef struct packed {
    dev_mode_t mode;
    wd_state_t wd_state;
    logic swe_running;
  } dev_status_t;
endpackage : spi_safety_pkg

/* File: hw/host_spi_safety_checks.sv */
// spi target with frame checks, watchdog windows and sleep-wake error timer
//
// Contract
// (R01) standby entry waits trigger within long window
// (R02) long window starts at reset output release
// (R03) after long window, programmed window or timeout
// (R04) normal entry starts programmed watchdog timing
// (R05) standby watchdog off: long window in normal
// (R06) crc checking off after reset, enable bit
// (R07) default crc poly 2F, init FF, xor FF
// (R08) select bit picks alternative poly 1D
// (R09) filler byte zero included in crc
// (R10) crc mismatch sets summary and crc flags
// (R11) crc failure discards the write
// (R12) crc off: frame exactly sixteen clocks
// (R13) crc on: frame exactly twenty-four clocks
// (R14) sample data on rising clock while selected
// (R15) write only on exact count then deselect
// (R16) wrong clock count sets length error flags
// (R17) scratch register stores and returns any byte
// (R18) pin mode: timer starts in fail-safe, restart
// (R19) wake leaves sleep; undervoltage timeout returns sleep
// (R20) spi mode: timer starts fail-safe, restart, standby
// (R21) standby needs spi transaction before timer expiry
// (R22) disable bit stops the sleep-wake timer; code only blocks its start at spi-mode mode entries
// (R23) timer duration from select field, default 5 min
// (R24) crc over command and data, msb first
`timescale 1ns/100ps
`include "spi_safety_cfg.svh"
module host_spi_safety_checks
  import spi_safety_pkg::*;
#(
  parameter int MS_CYCLES = `MS_TIME_NS / `SYS_PERIOD_NS,
  parameter logic [15:0] RESTART_MS = `RESTART_MS_DEFAULT
)(
  // system clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // spi link
  input wire logic link_sclk,
  input wire logic select_low_pin,
  input wire logic spi_data_in,
  output logic spi_data_out,
  output logic spi_data_out_en_low,
  // device conditions
  input wire logic wake_event,
  input wire logic core_supply_undervoltage,
  input wire logic pin_control_mode,
  // device outputs
  output logic reset_out_low,
  output dev_status_t dev_status
);
  // ****************************************
  // declarations
  // ****************************************
  localparam logic [15:0] WD_MS_TABLE [0:31] = '{
    16'h0004, 16'h0008, 16'h000C, 16'h0010, 16'h0020, 16'h0040, 16'h0060, 16'h0080,
    16'h0080, 16'h0100, 16'h0180, 16'h0200, 16'h0100, 16'h0180, 16'h0200, 16'h0300,
    16'h0200, 16'h0400, 16'h0600, 16'h0800, 16'h0800, 16'h1000, 16'h1800, 16'h2000,
    16'h2800, 16'h4F10, 16'h4F10, 16'h4F10, 16'h4F10, 16'h4F10, 16'h4F10, 16'h4F10};
  logic [23:0] lk_shift_reg;
  logic [4:0] lk_count_reg;
  logic lk_armed_reg, lk_start_tog_reg, lk_clock_tog_reg;
  logic lk_arm_set;
  logic [7:0] lk_hold_reg;
  logic sdo_reg;
  logic [7:0] rd_mux;
  logic [2:0] sel_sync_reg, wake_sync_reg, uv_sync_reg, pin_sync_reg;
  logic frame_open_reg, frame_end;
  frame_t frame;
  logic [4:0] frame_len;
  logic [7:0] crc_calc;
  logic len_ok, crc_ok, valid_frame, write_ok;
  logic [7:0] scratch_reg, crc_en_reg, crc_sel_reg, mode_ctrl_reg;
  logic [7:0] wd_one_reg, wd_two_reg, swe_cfg_reg;
  logic [7:0] flag_top_reg, flag_wd_reg, flag_comm_reg;
  logic kick, wd_cfg_write;
  logic [31:0] ms_div_reg;
  logic [9:0] ms_in_sec_reg;
  logic ms_tick, sec_tick;
  dev_mode_t mode_reg, mode_next;
  logic mode_change;
  logic [15:0] rst_ms_reg;
  logic reset_out_reg;
  logic [9:0] swe_sec_reg, swe_limit;
  logic swe_run_reg, swe_expired;
  wd_state_t wd_reg, wd_next, wd_prog;
  logic [15:0] wd_ms_reg, wd_total, wd_limit;
  logic wd_err, wd_error_reg, wd_restart, stby_wd;

  // msb-first crc over command and data byte
  function automatic logic [7:0] crc8(input logic [15:0] bits, input logic [7:0] poly);
    logic [7:0] c;
    logic fb;
    c = `CRC_INIT;
    for (int i = 15; i >= 0; i--)
    begin
      fb = c[7] ^ bits[i];
      c = {c[6:0], 1'b0};
      if (fb)
        c = c ^ poly;
    end
    return c ^ `CRC_XOR;
  endfunction : crc8

  // ****************************************
  // link domain: shifter and serial output
  // ****************************************
  assign lk_arm_set = select_low_pin | ~reset_n;
  // armed marks that the next clock is the first of a frame
  always_ff @(posedge link_sclk or posedge lk_arm_set)
  begin
    if (lk_arm_set)
      lk_armed_reg <= 1'b1;
    else
      lk_armed_reg <= 1'b0;
  end
  // select fall flips this and the first clock copies it, so a frame without clocks shows as a mismatch
  always_ff @(negedge select_low_pin or negedge reset_n)
  begin
    if (!reset_n)
      lk_start_tog_reg <= 1'b0;
    else
      lk_start_tog_reg <= ~lk_start_tog_reg;
  end
  // shift and count; both stay frozen after deselect, so the system side reads them quietly
  always_ff @(posedge link_sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lk_shift_reg <= '0;
      lk_count_reg <= '0;
      lk_clock_tog_reg <= 1'b0;
    end
    else
    begin
      lk_shift_reg <= {lk_shift_reg[22:0], spi_data_in}; // [R14]
      if (lk_armed_reg)
      begin
        lk_count_reg <= 5'h01;
        lk_clock_tog_reg <= lk_start_tog_reg; // first clock of the frame catches up
      end
      else if (lk_count_reg != 5'h1F)
        lk_count_reg <= lk_count_reg + 5'h01; // saturates so long frames still fail
    end
  end
  // read data: written registers change only between frames; the watchdog error flag and the restart clear of mode_ctrl_reg can land mid-frame
  always_comb
  begin
    rd_mux = `FILLER_BYTE;
    if (lk_shift_reg[7:1] == `ADDR_SCRATCH)
      rd_mux = scratch_reg;
    else if (lk_shift_reg[7:1] == `ADDR_CRC_EN)
      rd_mux = crc_en_reg;
    else if (lk_shift_reg[7:1] == `ADDR_CRC_SEL)
      rd_mux = crc_sel_reg;
    else if (lk_shift_reg[7:1] == `ADDR_MODE)
      rd_mux = mode_ctrl_reg;
    else if (lk_shift_reg[7:1] == `ADDR_WD_ONE)
      rd_mux = wd_one_reg;
    else if (lk_shift_reg[7:1] == `ADDR_WD_TWO)
      rd_mux = wd_two_reg;
    else if (lk_shift_reg[7:1] == `ADDR_SWE)
      rd_mux = swe_cfg_reg;
    else if (lk_shift_reg[7:1] == `ADDR_FLAG_TOP)
      rd_mux = flag_top_reg;
    else if (lk_shift_reg[7:1] == `ADDR_FLAG_WD)
      rd_mux = flag_wd_reg;
    else if (lk_shift_reg[7:1] == `ADDR_FLAG_COMM)
      rd_mux = flag_comm_reg;
  end
  // serial output changes on falling clock: zeros, then the read byte, then zeros
  always_ff @(negedge link_sclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sdo_reg <= 1'b0;
      lk_hold_reg <= '0;
    end
    else if (lk_count_reg == `CMD_BITS)
    begin
      sdo_reg <= rd_mux[7];
      lk_hold_reg <= {rd_mux[6:0], 1'b0};
    end
    else if (lk_count_reg > `CMD_BITS && lk_count_reg < `FRAME_SHORT)
    begin
      sdo_reg <= lk_hold_reg[7];
      lk_hold_reg <= {lk_hold_reg[6:0], 1'b0};
    end
    else
      sdo_reg <= 1'b0;
  end
  assign spi_data_out = sdo_reg;
  assign spi_data_out_en_low = select_low_pin;

  // ****************************************
  // input synchronisers and frame decode
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sel_sync_reg <= 3'b111;
      wake_sync_reg <= '0;
      uv_sync_reg <= '0;
      pin_sync_reg <= '0;
    end
    else if (clk_en)
    begin
      sel_sync_reg <= {sel_sync_reg[1:0], select_low_pin};
      wake_sync_reg <= {wake_sync_reg[1:0], wake_event};
      uv_sync_reg <= {uv_sync_reg[1:0], core_supply_undervoltage};
      pin_sync_reg <= {pin_sync_reg[1:0], pin_control_mode};
    end
  end
  // a frame ends on deselect only after a select was seen
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      frame_open_reg <= 1'b0;
    else if (clk_en)
    begin
      if (!sel_sync_reg[1] && sel_sync_reg[2])
        frame_open_reg <= 1'b1;
      else if (frame_end)
        frame_open_reg <= 1'b0;
    end
  end
  assign frame_end = clk_en & frame_open_reg & sel_sync_reg[1] & ~sel_sync_reg[2]; // [R15]
  assign frame_len = crc_en_reg[`BIT_ENABLE] ? `FRAME_LONG : `FRAME_SHORT; // [R12] [R13]
  // field split depends on frame length; the crc byte is last when enabled
  always_comb
  begin
    frame.clocks = lk_count_reg;
    frame.empty = lk_start_tog_reg ^ lk_clock_tog_reg; // armed is set again by deselect, so not usable here
    if (crc_en_reg[`BIT_ENABLE])
    begin
      frame.cmd = lk_shift_reg[23:16];
      frame.data = lk_shift_reg[15:8];
      frame.crc = lk_shift_reg[7:0];
    end
    else
    begin
      frame.cmd = lk_shift_reg[15:8];
      frame.data = lk_shift_reg[7:0];
      frame.crc = `FILLER_BYTE;
    end
  end
  // on reads the host sends the zero filler as data, so it enters the sum
  assign crc_calc = crc8({frame.cmd, frame.data}, // [R09] [R24]
    crc_sel_reg[`BIT_ENABLE] ? `CRC_POLY_ALT : `CRC_POLY_DEFAULT); // [R07] [R08]
  assign len_ok = !frame.empty && frame.clocks == frame_len; // [R16]
  assign crc_ok = !crc_en_reg[`BIT_ENABLE] || crc_calc == frame.crc; // [R06]
  assign valid_frame = frame_end && len_ok && crc_ok;
  assign write_ok = valid_frame && frame.cmd[`BIT_WRITE]; // [R11] [R15]
  assign kick = write_ok && frame.cmd[7:1] == `ADDR_WD_KICK;
  assign wd_cfg_write = write_ok && (frame.cmd[7:1] == `ADDR_WD_ONE || frame.cmd[7:1] == `ADDR_WD_TWO);

  // ****************************************
  // register file
  // ****************************************
  // flags are write-one-to-clear and a same-cycle set wins over the clear
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scratch_reg <= '0;
      crc_en_reg <= '0; // [R06]
      crc_sel_reg <= '0;
      mode_ctrl_reg <= '0;
      wd_one_reg <= `WD_ONE_RESET;
      wd_two_reg <= `WD_TWO_RESET;
      swe_cfg_reg <= `SWE_RESET;
      flag_top_reg <= '0;
      flag_wd_reg <= '0;
      flag_comm_reg <= '0;
    end
    else if (clk_en)
    begin
      if (write_ok)
      begin
        if (frame.cmd[7:1] == `ADDR_SCRATCH)
          scratch_reg <= frame.data; // [R17]
        else if (frame.cmd[7:1] == `ADDR_CRC_EN)
          crc_en_reg <= {7'h00, frame.data[`BIT_ENABLE]};
        else if (frame.cmd[7:1] == `ADDR_CRC_SEL)
          crc_sel_reg <= {7'h00, frame.data[`BIT_ENABLE]};
        else if (frame.cmd[7:1] == `ADDR_MODE)
          mode_ctrl_reg <= {7'h00, frame.data[`BIT_ENABLE]};
        else if (frame.cmd[7:1] == `ADDR_WD_ONE)
          wd_one_reg <= frame.data;
        else if (frame.cmd[7:1] == `ADDR_WD_TWO)
          wd_two_reg <= frame.data;
        else if (frame.cmd[7:1] == `ADDR_SWE)
          swe_cfg_reg <= frame.data; // [R22] [R23]
        else if (frame.cmd[7:1] == `ADDR_FLAG_TOP)
          flag_top_reg <= flag_top_reg & ~frame.data;
        else if (frame.cmd[7:1] == `ADDR_FLAG_WD)
          flag_wd_reg <= flag_wd_reg & ~frame.data;
        else if (frame.cmd[7:1] == `ADDR_FLAG_COMM)
          flag_comm_reg <= flag_comm_reg & ~frame.data;
      end
      if (mode_reg == MODE_RESTART)
        mode_ctrl_reg <= '0; // a restart always drops the normal request
      if (frame_end && !len_ok)
      begin
        flag_top_reg[`BIT_FLAG_ANY] <= 1'b1; // [R16]
        flag_top_reg[`BIT_FLAG_COMM] <= 1'b1;
        flag_comm_reg[`BIT_LEN_ERR] <= 1'b1;
      end
      if (frame_end && len_ok && !crc_ok)
      begin
        flag_top_reg[`BIT_FLAG_ANY] <= 1'b1; // [R10]
        flag_top_reg[`BIT_FLAG_COMM] <= 1'b1;
        flag_comm_reg[`BIT_CRC_ERR] <= 1'b1;
      end
      if (wd_error_reg)
        flag_wd_reg[`BIT_WD_ERR] <= 1'b1;
    end
  end

  // ****************************************
  // time base
  // ****************************************
  assign ms_tick = clk_en && ms_div_reg == 32'(MS_CYCLES - 1);
  assign sec_tick = ms_tick && ms_in_sec_reg == `MS_PER_SEC - 10'h001;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ms_div_reg <= '0;
      ms_in_sec_reg <= '0;
    end
    else if (clk_en)
    begin
      ms_div_reg <= ms_tick ? '0 : ms_div_reg + 32'h0000_0001;
      if (ms_tick)
        ms_in_sec_reg <= sec_tick ? '0 : ms_in_sec_reg + 10'h001;
    end
  end

  // ****************************************
  // operating mode
  // ****************************************
  always_comb
  begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_SLEEP:
        if (wake_sync_reg[1])
          mode_next = MODE_RESTART; // [R19]
      MODE_RESTART:
        if (swe_expired)
          mode_next = MODE_SLEEP; // [R19]
        else if (rst_ms_reg >= RESTART_MS && !uv_sync_reg[1])
          mode_next = MODE_STANDBY;
      MODE_STANDBY:
        if (uv_sync_reg[1] || swe_expired)
          mode_next = MODE_FAIL_SAFE; // [R21]
        else if (wd_error_reg)
          mode_next = MODE_RESTART;
        else if (mode_ctrl_reg[`BIT_ENABLE])
          mode_next = MODE_NORMAL;
      MODE_NORMAL:
        if (uv_sync_reg[1])
          mode_next = MODE_FAIL_SAFE;
        else if (wd_error_reg)
          mode_next = MODE_RESTART;
        else if (!mode_ctrl_reg[`BIT_ENABLE])
          mode_next = MODE_STANDBY;
      MODE_FAIL_SAFE:
        if (swe_expired)
          mode_next = MODE_SLEEP;
        else if (wake_sync_reg[1] && !uv_sync_reg[1])
          mode_next = MODE_RESTART;
      default:
        mode_next = MODE_RESTART;
    endcase
  end
  assign mode_change = clk_en && mode_next != mode_reg;
  // reset output is low exactly while in restart
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_reg <= MODE_RESTART;
      reset_out_reg <= 1'b0;
      rst_ms_reg <= '0;
    end
    else if (clk_en)
    begin
      mode_reg <= mode_next;
      reset_out_reg <= mode_next != MODE_RESTART;
      if (mode_change)
        rst_ms_reg <= '0;
      else if (ms_tick && rst_ms_reg != 16'hFFFF)
        rst_ms_reg <= rst_ms_reg + 16'h0001;
    end
  end
  assign reset_out_low = reset_out_reg;

  // ****************************************
  // sleep-wake error timer
  // ****************************************
  // duration: 30 s steps up to the 5 min default code, 60 s steps above, capped at 10 min
  always_comb
  begin
    if (swe_cfg_reg[`SWE_SEL_HI:`SWE_SEL_LO] <= `SWE_KNEE)
      swe_limit = 10'(`SWE_BASE_SEC * ({6'h00, swe_cfg_reg[`SWE_SEL_HI:`SWE_SEL_LO]} + 10'h001)); // [R23]
    else
      swe_limit = 10'(`SWE_BASE_SEC * ({6'h00, `SWE_KNEE} + 10'h001)
        + `SWE_HI_STEP * {6'h00, swe_cfg_reg[`SWE_SEL_HI:`SWE_SEL_LO] - `SWE_KNEE});
    if (swe_limit > `SWE_MAX_SEC)
      swe_limit = `SWE_MAX_SEC;
  end
  assign swe_expired = swe_run_reg && swe_sec_reg >= swe_limit;
  // count clears on every mode entry and runs again only for enabled modes; only one second of granularity is needed
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      swe_run_reg <= 1'b0;
      swe_sec_reg <= '0;
    end
    else if (clk_en)
    begin
      if (mode_change)
      begin
        swe_sec_reg <= '0;
        if (pin_sync_reg[1])
          swe_run_reg <= mode_next == MODE_FAIL_SAFE || mode_next == MODE_RESTART; // [R18]
        else
          swe_run_reg <= !swe_cfg_reg[`BIT_SWE_DIS] && (mode_next == MODE_FAIL_SAFE // [R20] [R22]
            || mode_next == MODE_RESTART || mode_next == MODE_STANDBY);
      end
      else if (valid_frame && mode_reg == MODE_STANDBY)
        swe_run_reg <= 1'b0; // [R21]
      else if (sec_tick && swe_run_reg && !swe_expired)
        swe_sec_reg <= swe_sec_reg + 10'h001;
    end
  end

  // ****************************************
  // watchdog
  // ****************************************
  assign stby_wd = wd_one_reg[`BIT_WD_STBY];
  assign wd_total = WD_MS_TABLE[{wd_two_reg[`WD_TIMER_HI:`WD_TIMER_LO], wd_one_reg[`WD_PRE_HI:`WD_PRE_LO]}];
  assign wd_prog = wd_one_reg[`BIT_WD_TYPE] ? WD_TIMEOUT : WD_CLOSED; // [R03]
  always_comb
  begin
    wd_limit = wd_total;
    if (wd_reg == WD_LONG)
      wd_limit = `INIT_WIN_MS;
    else if (wd_reg == WD_CLOSED || wd_reg == WD_OPEN)
      wd_limit = wd_total >> 1; // equal closed and open halves
  end
  always_comb
  begin
    wd_next = wd_reg;
    wd_err = 1'b0;
    wd_restart = 1'b0;
    if (mode_change)
    begin
      wd_restart = 1'b1;
      if (mode_next == MODE_STANDBY && stby_wd)
        wd_next = WD_LONG; // [R01] [R02]
      else if (mode_next == MODE_NORMAL)
        wd_next = (mode_reg == MODE_STANDBY && stby_wd) ? wd_prog : WD_LONG; // [R04] [R05]
      else
        wd_next = WD_IDLE;
    end
    else if (wd_cfg_write && wd_reg != WD_IDLE)
    begin
      wd_restart = 1'b1;
      wd_next = wd_prog;
    end
    else
    begin
      case (wd_reg)
        WD_LONG, WD_OPEN, WD_TIMEOUT:
          if (kick)
          begin
            wd_restart = 1'b1;
            wd_next = wd_prog; // [R03]
          end
          else if (ms_tick && wd_ms_reg + 16'h0001 >= wd_limit)
          begin
            wd_err = 1'b1; // [R01]
            wd_next = WD_IDLE;
          end
        WD_CLOSED:
          if (kick)
          begin
            wd_err = 1'b1; // trigger in the closed half is an error
            wd_next = WD_IDLE;
          end
          else if (ms_tick && wd_ms_reg + 16'h0001 >= wd_limit)
          begin
            wd_restart = 1'b1;
            wd_next = WD_OPEN;
          end
        default:
          wd_next = WD_IDLE;
      endcase
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wd_reg <= WD_IDLE;
      wd_ms_reg <= '0;
      wd_error_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      wd_reg <= wd_next;
      wd_error_reg <= wd_err;
      if (wd_restart)
        wd_ms_reg <= '0;
      else if (ms_tick)
        wd_ms_reg <= wd_ms_reg + 16'h0001;
    end
  end
  assign dev_status = '{mode: mode_reg, wd_state: wd_reg, swe_running: swe_run_reg};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  chk_len_error_flags: assert property (frame_end && !len_ok |=> flag_comm_reg[7] && flag_top_reg[7] // [R16]
    && flag_top_reg[4]) else $error("length error flags not set");
  chk_crc_error_flags: assert property (frame_end && len_ok && !crc_ok |=> flag_comm_reg[4] && flag_top_reg[7] // [R10]
    && flag_top_reg[4]) else $error("crc error flags not set");
  chk_bad_write_kept: assert property (frame_end && !write_ok |=> $stable(scratch_reg)) // [R11]
    else $error("rejected frame changed a register");
  chk_scratch_store: assert property (write_ok && frame.cmd[7:1] == 7'h0F |=> scratch_reg == $past(frame.data)) // [R17]
    else $error("scratch register did not store data");
  chk_crc_off_reset: assert property ($rose(crc_en_reg[`BIT_ENABLE]) |-> // [R06]
    $past(write_ok && frame.cmd[7:1] == `ADDR_CRC_EN)) else $error("crc enabled without a write");
  chk_long_window_start: assert property ($rose(reset_out_low) && stby_wd |-> wd_reg == WD_LONG // [R02]
    && wd_ms_reg == 16'h0000) else $error("long window not started at reset release");
  chk_normal_prog: assert property (mode_reg == MODE_STANDBY && mode_next == MODE_NORMAL && stby_wd && clk_en // [R04]
    |=> wd_reg == $past(wd_prog)) else $error("normal mode did not start programmed watchdog");
  chk_normal_long: assert property (mode_reg == MODE_STANDBY && mode_next == MODE_NORMAL && !stby_wd && clk_en // [R05]
    |=> wd_reg == WD_LONG) else $error("normal mode missed long window");
  chk_swe_failsafe: assert property (mode_reg == MODE_STANDBY && swe_expired && clk_en |=> // [R21]
    mode_reg == MODE_FAIL_SAFE) else $error("standby timeout did not enter fail-safe");
  chk_swe_disabled: assert property (mode_change && !pin_sync_reg[1] && swe_cfg_reg[7] |=> !swe_run_reg) // [R22]
    else $error("disabled sleep-wake timer started");
  chk_wake_restart: assert property (mode_reg == MODE_SLEEP && wake_sync_reg[1] && clk_en |=> // [R19]
    mode_reg == MODE_RESTART ##1 !reset_out_low) else $error("wake did not enter restart");
  cov_crc_write: cover property (write_ok && crc_en_reg[0]);
  cov_len_error: cover property (frame_end && !len_ok);
  cov_long_kick: cover property (wd_reg == WD_LONG && kick);
  cov_standby_timeout: cover property (mode_reg == MODE_STANDBY ##1 mode_reg == MODE_FAIL_SAFE);
endmodule : host_spi_safety_checks

/* File: tb/spi_host_model.sv */
// host controller model that drives the spi link
`timescale 1ns/100ps
module spi_host_model (
  // spi link
  output logic link_sclk,
  output logic select_low_pin,
  output logic spi_data_in,
  input wire logic spi_data_out
);
  // idle: clock stands low, select high, data at its pull-up level
  initial
  begin
    link_sclk = 1'b0;
    select_low_pin = 1'b1;
    spi_data_in = 1'b1;
  end
  // one frame of n clocks, msb first; byte two is captured on rising edges
  task automatic xfer(input logic [23:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    select_low_pin = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      spi_data_in = tx[23 - i];
      #6 link_sclk = 1'b1;
      if (i > 7 && i < 16) rx = {rx[6:0], spi_data_out};
      #6 link_sclk = 1'b0;
    end
    #6 select_low_pin = 1'b1;
    spi_data_in = 1'b1;
  endtask : xfer
endmodule : spi_host_model

/* File: tb/host_spi_safety_checks_bench.sv */
// self-checking bench for the spi safety block
`timescale 1ns/100ps
`include "spi_safety_cfg.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module host_spi_safety_checks_bench;
  import spi_safety_pkg::*;
  logic sys_clk, reset_n, clk_en, link_sclk, select_low_pin, spi_data_in, spi_data_out;
  logic wake_event, core_supply_undervoltage, pin_control_mode, reset_out_low;
  dev_status_t dev_status;
  int errors, samples_checked, k;
  logic crc_on, alt, data_oe_low;
  logic [7:0] rx;
  // ****************
  // design and host
  // ****************
  host_spi_safety_checks #(.MS_CYCLES(10), .RESTART_MS(16'h0002)) host_spi_safety_checks_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .link_sclk(link_sclk),
    .select_low_pin(select_low_pin), .spi_data_in(spi_data_in), .spi_data_out(spi_data_out),
    .spi_data_out_en_low(data_oe_low), .wake_event(wake_event), .core_supply_undervoltage(core_supply_undervoltage),
    .pin_control_mode(pin_control_mode), .reset_out_low(reset_out_low), .dev_status(dev_status));
  spi_host_model spi_host_model_i (.link_sclk(link_sclk), .select_low_pin(select_low_pin),
    .spi_data_in(spi_data_in), .spi_data_out(spi_data_out));
  // 10 mhz system clock
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // crc over command then data, msb first, init and final xor ff
  function automatic logic [7:0] crc(input logic [15:0] v);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? (alt ? 8'h1D : 8'h2F) : 8'h00);
    return c ^ 8'hFF;
  endfunction : crc
  // one frame; reads send the zero filler, bad flips the crc; then the gap between frames
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d, input int n, input logic bad);
    logic [15:0] v;
    v = {a, w, (w ? d : 8'h00)};
    spi_host_model_i.xfer({v, crc(v) ^ {7'h00, bad}}, n, rx);
    repeat (8) @(posedge sys_clk);
  endtask : frame
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frame(a, 1'b1, d, (crc_on ? 24 : 16), 1'b0);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    frame(a, 1'b0, 8'h00, (crc_on ? 24 : 16), 1'b0);
    `CHK(rx, e)
  endtask : rd
  task automatic print_verdict;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // ****************
  // main sequence
  // ****************
  initial
  begin
    errors = 0; samples_checked = 0; crc_on = 1'b0; alt = 1'b0;
    reset_n = 1'b0; clk_en = 1'b1; wake_event = 1'b0;
    core_supply_undervoltage = 1'b0; pin_control_mode = 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (k = 0; k < 200 && reset_out_low !== 1'b1; k++) @(posedge sys_clk);
    if (k == 200) begin errors++; print_verdict(); end
    @(negedge sys_clk);
    `CHK(dev_status.mode, MODE_STANDBY)
    `CHK(dev_status.wd_state, WD_LONG)
    `CHK(dev_status.swe_running, 1'b1)
    `CHK(data_oe_low, 1'b1)
    wr(`ADDR_SCRATCH, 8'hA5);
    `CHK(dev_status.swe_running, 1'b0)
    rd(`ADDR_SCRATCH, 8'hA5);
    frame(`ADDR_SCRATCH, 1'b1, 8'h3C, 15, 1'b0);
    rd(`ADDR_SCRATCH, 8'hA5);
    rd(`ADDR_FLAG_COMM, 8'h80);
    rd(`ADDR_FLAG_TOP, 8'h90);
    wr(`ADDR_FLAG_COMM, 8'h80);
    wr(`ADDR_WD_KICK, 8'h00);
    `CHK(dev_status.wd_state, WD_CLOSED)
    wr(`ADDR_CRC_EN, 8'h01);
    crc_on = 1'b1;
    // both polynomials: good write lands, bad crc is refused and flagged
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1) begin wr(`ADDR_CRC_SEL, 8'h01); alt = 1'b1; end
      wr(`ADDR_SCRATCH, 8'h5A + p[7:0]);
      rd(`ADDR_SCRATCH, 8'h5A + p[7:0]);
      frame(`ADDR_SCRATCH, 1'b1, 8'hC3, 24, 1'b1);
      rd(`ADDR_SCRATCH, 8'h5A + p[7:0]);
      rd(`ADDR_FLAG_COMM, 8'h10);
      wr(`ADDR_FLAG_COMM, 8'h10);
    end
    print_verdict();
  end
endmodule : host_spi_safety_checks_bench
